// [shared/gpib_cfg.svh]
// constants for the instrument-side gpib interface
`ifndef GPIB_CFG_SVH
`define GPIB_CFG_SVH
`define GPIB_DATA_W 8
`define GPIB_FIFO_DEPTH 4
// interface message codes (7-bit, parity bit ignored)
`define GPIB_MSG_GTL 7'h01
`define GPIB_MSG_SDC 7'h04
`define GPIB_MSG_PPC 7'h05
`define GPIB_MSG_GET 7'h08
`define GPIB_MSG_LLO 7'h11
`define GPIB_MSG_DCL 7'h14
`define GPIB_MSG_PPU 7'h15
`define GPIB_MSG_SPE 7'h18
`define GPIB_MSG_SPD 7'h19
`define GPIB_MSG_UNL 7'h3F
`define GPIB_MSG_UNT 7'h5F
`define GPIB_LAD_BASE 2'h1
`define GPIB_TAD_BASE 2'h2
`define GPIB_PPE_BASE 3'h6
`define GPIB_PPD_CODE 7'h70
// serial poll status bit carrying the service request
`define GPIB_RQS_BIT 6
`endif

// [shared/gpib_pkg.sv]
// types for the instrument-side gpib interface
package gpib_pkg;
    // data byte with its end flag
    typedef struct packed
    {
        logic eoi;
        logic [7:0] data;
    } gpib_byte_type;
    // bus lines as seen by the device, all active low like the cable
    typedef struct packed
    {
        logic ifc_n;
        logic atn_n;
        logic ren_n;
        logic eoi_n;
        logic dav_n;
        logic nrfd_n;
        logic ndac_n;
        logic [7:0] dio_n;
    } gpib_bus_in_type;
    typedef enum logic [1:0] {GPIB_SRC_IDLE, GPIB_SRC_WAIT_RFD, GPIB_SRC_WAIT_DAC, GPIB_SRC_RELEASE} gpib_src_type;
    typedef enum logic [1:0] {GPIB_ACP_READY, GPIB_ACP_HOLD, GPIB_ACP_WAIT_END} gpib_acp_type;
endpackage : gpib_pkg

// [hw/gpib_fifo.sv]
// small valid/ready fifo for outgoing talker bytes
`timescale 1ns/1ps
module gpib_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_flush,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [WIDTH-1:0] o_rdata,
    output logic o_rvalid,
    input wire logic i_rready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH]; // storage
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d; // pointers
    logic [AW:0] cnt_q, cnt_d; // fill level
    logic wr, rd;
    // pointer and count update
    always_comb
    begin
        wr = i_wvalid && o_wready;
        rd = o_rvalid && i_rready;
        wp_d = wr ? AW'(wp_q + 1'b1) : wp_q;
        rp_d = rd ? AW'(rp_q + 1'b1) : rp_q;
        cnt_d = AW'(0) + cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
        if (i_flush)
        begin
            wp_d = '0;
            rp_d = '0;
            cnt_d = '0;
        end
    end
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end
    // data array, no reset needed
    always_ff @(posedge i_clk)
    begin
        if (wr)
        begin
            mem_q[wp_q] <= i_wdata;
        end
    end
    assign o_wready = (cnt_q != (AW+1)'(DEPTH));
    assign o_rvalid = (cnt_q != '0);
    assign o_rdata = mem_q[rp_q];
endmodule : gpib_fifo

// [hw/gpib_device.sv]
// instrument-side gpib interface functions: sh, ah, t, l, sr, pp, rl, dc, dt
`timescale 1ns/1ps
`include "gpib_cfg.svh"
module gpib_device (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic [4:0] I_MY_ADDR,
    input wire gpib_pkg::gpib_bus_in_type I_BUS,
    output logic [7:0] O_DIO_N,
    output logic O_DIO_OE_N,
    output logic O_DAV_N,
    output logic O_DAV_OE_N,
    output logic O_EOI_N,
    output logic O_EOI_OE_N,
    output logic O_NRFD_N,
    output logic O_NRFD_OE_N,
    output logic O_NDAC_N,
    output logic O_NDAC_OE_N,
    output logic O_SRQ_N,
    output logic O_SRQ_OE_N,
    input wire gpib_pkg::gpib_byte_type I_TX,
    input wire logic I_TX_VALID,
    output logic O_TX_READY,
    output gpib_pkg::gpib_byte_type O_RX,
    output logic O_RX_VALID,
    input wire logic I_RX_READY,
    input wire logic I_RSV,
    input wire logic [6:0] I_STATUS,
    input wire logic I_IST,
    output logic O_REMOTE,
    output logic O_LOCKOUT,
    output logic O_LISTEN,
    output logic O_TALK,
    output logic O_DEV_CLEAR,
    output logic O_TRIGGER
);
    import gpib_pkg::*;

    gpib_src_type src_q, src_d; // source handshake state
    gpib_acp_type acp_q, acp_d; // acceptor handshake state
    logic lads_q, lads_d, tads_q, tads_d, spms_q, spms_d; // addressing and serial poll mode
    logic rem_q, rem_d, llo_q, llo_d; // remote and lockout
    logic ppen_q, ppen_d, ppsense_q, ppsense_d; // parallel poll config
    logic [2:0] ppline_q, ppline_d;
    logic pacs_q, pacs_d; // ppe/ppd may follow
    logic srq_q, srq_d, spsent_q, spsent_d; // service request
    logic [7:0] dio_q, dio_d; // driven data, active high
    logic dio_en_q, dio_en_d, eoi_q, eoi_d;
    logic clr_q, clr_d, trg_q, trg_d; // one-cycle device events
    logic [7:0] rxb_q, rxb_d; // received byte
    logic rxe_q, rxe_d, rxv_q, rxv_d;
    logic [7:0] bus_byte;
    logic [6:0] cmd;
    logic atn, ifc, got_byte, ppoll;
    gpib_byte_type fifo_q;
    logic fifo_v, fifo_pop;
    logic [7:0] pp_mask;
    logic acp_on, nrfd_pull, ndac_pull; // acceptor line levels, high = pull low

    // outgoing bytes are buffered so the user side can run ahead of the bus
    gpib_fifo #(.WIDTH(9), .DEPTH(`GPIB_FIFO_DEPTH)) u_txq (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_flush(ifc || clr_q),
        .i_wdata(I_TX),
        .i_wvalid(I_TX_VALID),
        .o_wready(O_TX_READY),
        .o_rdata(fifo_q),
        .o_rvalid(fifo_v),
        .i_rready(fifo_pop)
    );

    // decode bus levels, inverting to positive logic
    always_comb
    begin
        atn = !I_BUS.atn_n;
        ifc = !I_BUS.ifc_n;
        bus_byte = ~I_BUS.dio_n;
        cmd = bus_byte[6:0];
        got_byte = (acp_q == GPIB_ACP_READY) && !I_BUS.dav_n;
        ppoll = atn && !I_BUS.eoi_n;
        pp_mask = 8'h01 << ppline_q;
    end

    // acceptor handshake, addressing, remote/local, clear, trigger
    always_comb
    begin
        acp_d = acp_q;
        lads_d = lads_q;
        tads_d = tads_q;
        spms_d = spms_q;
        rem_d = rem_q;
        llo_d = llo_q;
        ppen_d = ppen_q;
        ppsense_d = ppsense_q;
        ppline_d = ppline_q;
        pacs_d = pacs_q;
        clr_d = 1'b0;
        trg_d = 1'b0;
        rxb_d = rxb_q;
        rxe_d = rxe_q;
        rxv_d = rxv_q && !I_RX_READY;
        unique case (acp_q)
            GPIB_ACP_READY:
            begin
                // a data byte for us waits until the user took the previous one
                if (got_byte && (atn || (lads_q && !rxv_q)))
                begin
                    acp_d = GPIB_ACP_HOLD;
                    if (atn)
                    begin
                        pacs_d = 1'b0;
                        if (cmd[6:5] == `GPIB_LAD_BASE && cmd[4:0] == I_MY_ADDR)
                        begin
                            lads_d = 1'b1;
                            tads_d = 1'b0;
                        end
                        else if (cmd[6:5] == `GPIB_TAD_BASE && cmd[4:0] == I_MY_ADDR)
                        begin
                            tads_d = 1'b1;
                            lads_d = 1'b0;
                        end
                        else if (cmd[6:5] == `GPIB_TAD_BASE || cmd == `GPIB_MSG_UNT)
                        begin
                            tads_d = 1'b0;
                        end
                        else if (cmd == `GPIB_MSG_UNL)
                        begin
                            lads_d = 1'b0;
                        end
                        else if (cmd == `GPIB_MSG_SPE)
                        begin
                            spms_d = 1'b1;
                        end
                        else if (cmd == `GPIB_MSG_SPD)
                        begin
                            spms_d = 1'b0;
                        end
                        else if (cmd == `GPIB_MSG_DCL || (cmd == `GPIB_MSG_SDC && lads_q))
                        begin
                            clr_d = 1'b1;
                        end
                        else if (cmd == `GPIB_MSG_GET && lads_q)
                        begin
                            trg_d = 1'b1;
                        end
                        else if (cmd == `GPIB_MSG_GTL && lads_q)
                        begin
                            rem_d = 1'b0;
                        end
                        else if (cmd == `GPIB_MSG_LLO)
                        begin
                            llo_d = 1'b1;
                        end
                        else if (cmd == `GPIB_MSG_PPU)
                        begin
                            ppen_d = 1'b0;
                        end
                        else if (cmd == `GPIB_MSG_PPC && lads_q)
                        begin
                            pacs_d = 1'b1;
                        end
                        else if (pacs_q && cmd[6:4] == `GPIB_PPE_BASE)
                        begin
                            ppen_d = 1'b1;
                            ppsense_d = cmd[3];
                            ppline_d = cmd[2:0];
                            pacs_d = 1'b1;
                        end
                        else if (pacs_q && cmd[6:4] == 3'h7)
                        begin
                            ppen_d = 1'b0;
                            pacs_d = 1'b1;
                        end
                        // listen address turns remote on while ren is low
                        if (cmd[6:5] == `GPIB_LAD_BASE && cmd[4:0] == I_MY_ADDR && !I_BUS.ren_n)
                        begin
                            rem_d = 1'b1;
                        end
                    end
                    else
                    begin
                        rxb_d = bus_byte;
                        rxe_d = !I_BUS.eoi_n;
                        rxv_d = 1'b1;
                    end
                end
            end
            GPIB_ACP_HOLD:
            begin
                acp_d = GPIB_ACP_WAIT_END;
            end
            GPIB_ACP_WAIT_END:
            begin
                if (I_BUS.dav_n)
                begin
                    acp_d = GPIB_ACP_READY;
                end
            end
            default:
            begin
                acp_d = GPIB_ACP_READY;
            end
        endcase
        if (I_BUS.ren_n)
        begin
            rem_d = 1'b0;
            llo_d = 1'b0;
        end
        if (ifc)
        begin
            acp_d = GPIB_ACP_READY;
            lads_d = 1'b0;
            tads_d = 1'b0;
            spms_d = 1'b0;
            pacs_d = 1'b0;
            rxv_d = 1'b0;
        end
        // acceptor stays off the bus unless addressed or under attention, so our own talker is not stalled
        acp_on = atn || lads_d;
        // a listener with a full receive byte is not ready for the next one
        nrfd_pull = acp_on && ((acp_d != GPIB_ACP_READY) || (!atn && rxv_d));
        ndac_pull = acp_on && (acp_d != GPIB_ACP_WAIT_END);
    end

    // source handshake, talker data and srq
    always_comb
    begin
        src_d = src_q;
        dio_d = dio_q;
        dio_en_d = 1'b0;
        eoi_d = 1'b0;
        fifo_pop = 1'b0;
        srq_d = I_RSV && !spsent_q;
        spsent_d = spsent_q && I_RSV;
        if (ppoll && ppen_q)
        begin
            dio_en_d = (I_IST == ppsense_q);
            dio_d = pp_mask;
            src_d = GPIB_SRC_IDLE;
        end
        else
        begin
            unique case (src_q)
                GPIB_SRC_IDLE:
                begin
                    if (!atn && tads_q && (spms_q || fifo_v))
                    begin
                        src_d = GPIB_SRC_WAIT_RFD;
                    end
                end
                GPIB_SRC_WAIT_RFD:
                begin
                    dio_en_d = 1'b1;
                    dio_d = spms_q ? {1'b0, srq_q, I_STATUS[5:0]} : fifo_q.data;
                    eoi_d = !spms_q && fifo_q.eoi;
                    if (atn)
                    begin
                        src_d = GPIB_SRC_IDLE;
                    end
                    else if (!I_BUS.nrfd_n == 1'b0 && dio_en_q)
                    begin
                        src_d = GPIB_SRC_WAIT_DAC;
                    end
                end
                GPIB_SRC_WAIT_DAC:
                begin
                    dio_en_d = 1'b1;
                    eoi_d = eoi_q;
                    if (I_BUS.ndac_n)
                    begin
                        src_d = GPIB_SRC_RELEASE;
                        if (spms_q)
                        begin
                            spsent_d = srq_q;
                        end
                        else
                        begin
                            fifo_pop = 1'b1;
                        end
                    end
                end
                GPIB_SRC_RELEASE:
                begin
                    // dav already released, wait for the acceptors to rearm
                    if (!I_BUS.ndac_n || atn)
                    begin
                        src_d = GPIB_SRC_IDLE;
                    end
                end
            endcase
        end
        if (ifc)
        begin
            src_d = GPIB_SRC_IDLE;
            dio_en_d = 1'b0;
            eoi_d = 1'b0;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            src_q <= GPIB_SRC_IDLE;
            acp_q <= GPIB_ACP_READY;
            lads_q <= 1'b0;
            tads_q <= 1'b0;
            spms_q <= 1'b0;
            rem_q <= 1'b0;
            llo_q <= 1'b0;
            ppen_q <= 1'b0;
            ppsense_q <= 1'b0;
            ppline_q <= 3'h0;
            pacs_q <= 1'b0;
            srq_q <= 1'b0;
            spsent_q <= 1'b0;
            dio_q <= 8'h00;
            dio_en_q <= 1'b0;
            eoi_q <= 1'b0;
            clr_q <= 1'b0;
            trg_q <= 1'b0;
            rxb_q <= 8'h00;
            rxe_q <= 1'b0;
            rxv_q <= 1'b0;
        end
        else
        begin
            src_q <= src_d;
            acp_q <= acp_d;
            lads_q <= lads_d;
            tads_q <= tads_d;
            spms_q <= spms_d;
            rem_q <= rem_d;
            llo_q <= llo_d;
            ppen_q <= ppen_d;
            ppsense_q <= ppsense_d;
            ppline_q <= ppline_d;
            pacs_q <= pacs_d;
            srq_q <= srq_d;
            spsent_q <= spsent_d;
            dio_q <= dio_d;
            dio_en_q <= dio_en_d;
            eoi_q <= eoi_d;
            clr_q <= clr_d;
            trg_q <= trg_d;
            rxb_q <= rxb_d;
            rxe_q <= rxe_d;
            rxv_q <= rxv_d;
        end
    end

    // pin drivers come straight from flops; enables are active low
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            O_DIO_N <= 8'hFF;
            O_DIO_OE_N <= 1'b1;
            O_DAV_N <= 1'b1;
            O_DAV_OE_N <= 1'b1;
            O_EOI_N <= 1'b1;
            O_EOI_OE_N <= 1'b1;
            O_NRFD_N <= 1'b1;
            O_NRFD_OE_N <= 1'b1;
            O_NDAC_N <= 1'b1;
            O_NDAC_OE_N <= 1'b1;
            O_SRQ_N <= 1'b1;
            O_SRQ_OE_N <= 1'b1;
        end
        else
        begin
            O_DIO_N <= ~dio_d;
            O_DIO_OE_N <= !dio_en_d;
            O_DAV_N <= !(src_d == GPIB_SRC_WAIT_DAC);
            O_DAV_OE_N <= !(src_d == GPIB_SRC_WAIT_DAC);
            O_EOI_N <= !eoi_d;
            O_EOI_OE_N <= !eoi_d;
            O_NRFD_N <= !nrfd_pull;
            O_NRFD_OE_N <= !nrfd_pull;
            O_NDAC_N <= !ndac_pull;
            O_NDAC_OE_N <= !ndac_pull;
            O_SRQ_N <= !srq_d;
            O_SRQ_OE_N <= !srq_d;
        end
    end

    assign O_RX = '{eoi: rxe_q, data: rxb_q};
    assign O_RX_VALID = rxv_q;
    assign O_REMOTE = rem_q;
    assign O_LOCKOUT = llo_q;
    assign O_LISTEN = lads_q;
    assign O_TALK = tads_q;
    assign O_DEV_CLEAR = clr_q;
    assign O_TRIGGER = trg_q;
endmodule : gpib_device

// [testbench/gpib_device_asserts.sv]
// pin-level assertions for the gpib device, bound to its top module
`timescale 1ns/1ps
module gpib_device_asserts (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire gpib_pkg::gpib_bus_in_type I_BUS,
    input wire logic [7:0] O_DIO_N,
    input wire logic O_DIO_OE_N,
    input wire logic O_DAV_OE_N,
    input wire logic O_NRFD_OE_N,
    input wire logic O_NDAC_OE_N,
    input wire logic O_SRQ_N,
    input wire logic O_SRQ_OE_N,
    input wire logic I_RSV,
    input wire logic O_REMOTE,
    input wire logic O_LISTEN,
    input wire logic O_TALK,
    input wire logic O_TRIGGER
);
    import gpib_pkg::*;
    // one clock domain, so clock and disable are given once
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SRST);
    a_dav_has_data: assert property (!O_DAV_OE_N |-> !O_DIO_OE_N)
        else $error("dav pulled without data driven");
    a_dav_waits_rfd: assert property ($fell(O_DAV_OE_N) |-> $past(I_BUS.nrfd_n))
        else $error("dav pulled while nrfd low");
    // byte and strobe must hold while any acceptor still has ndac low
    a_dav_holds_byte: assert property ((!O_DAV_OE_N && !I_BUS.ndac_n && I_BUS.atn_n && I_BUS.ifc_n)
        |=> (!O_DAV_OE_N && $stable(O_DIO_N)))
        else $error("source let go before acceptance");
    a_dav_release: assert property ((!O_DAV_OE_N && I_BUS.ndac_n) |=> O_DAV_OE_N)
        else $error("dav not released after ndac high");
    a_ndac_on_dav: assert property (($rose(O_NDAC_OE_N) && !I_BUS.atn_n && I_BUS.ifc_n)
        |-> $past(!I_BUS.dav_n))
        else $error("ndac released with no byte on bus");
    a_nrfd_held: assert property ((!O_NRFD_OE_N && !I_BUS.dav_n && O_DAV_OE_N && I_BUS.ifc_n)
        |=> !O_NRFD_OE_N)
        else $error("nrfd released while dav still low");
    a_srq_cause: assert property ($fell(O_SRQ_OE_N) |-> $past(I_RSV))
        else $error("srq pulled without request");
    a_srq_level: assert property (!O_SRQ_OE_N |-> !O_SRQ_N)
        else $error("srq driven high");
    a_ifc_idle: assert property ((!I_BUS.ifc_n ##1 !I_BUS.ifc_n) |=> (!O_LISTEN && !O_TALK && O_DAV_OE_N))
        else $error("interface clear did not idle functions");
    a_remote_ren: assert property ($rose(O_REMOTE) |-> $past(!I_BUS.ren_n))
        else $error("remote entered without ren");
    a_listen_talk: assert property (!(O_LISTEN && O_TALK))
        else $error("listener and talker at once");
    a_trig_pulse: assert property (O_TRIGGER |=> !O_TRIGGER)
        else $error("trigger longer than one cycle");
endmodule : gpib_device_asserts
bind gpib_device gpib_device_asserts gpib_device_asserts_i (.I_CLK, .I_SRST, .I_BUS, .O_DIO_N, .O_DIO_OE_N,
    .O_DAV_OE_N, .O_NRFD_OE_N, .O_NDAC_OE_N, .O_SRQ_N, .O_SRQ_OE_N, .I_RSV, .O_REMOTE, .O_LISTEN, .O_TALK,
    .O_TRIGGER);

// [testbench/gpib_ctrl_model.sv]
// system controller model: resolves the open-drain lines and runs both handshakes
`timescale 1ns/1ps
module gpib_ctrl_model (
    input wire logic i_clk,
    input wire logic [7:0] i_dio_n,
    input wire logic i_dio_oe_n,
    input wire logic i_dav_n,
    input wire logic i_dav_oe_n,
    input wire logic i_eoi_n,
    input wire logic i_eoi_oe_n,
    input wire logic i_nrfd_n,
    input wire logic i_nrfd_oe_n,
    input wire logic i_ndac_n,
    input wire logic i_ndac_oe_n,
    output gpib_pkg::gpib_bus_in_type o_bus
);
    import gpib_pkg::*;
    logic c_ifc_n = 1'b1; // control lines, pulled up when released
    logic c_atn_n = 1'b1;
    logic c_ren_n = 1'b1;
    logic c_eoi_n = 1'b1;
    logic c_dav_n = 1'b1;
    logic c_nrfd_n = 1'b1;
    logic c_ndac_n = 1'b1;
    logic [7:0] c_dio_n = 8'hFF; // released data lines read high
    int faults = 0; // handshake waits that ran out
    // wired-and of every party, a pulled line wins
    assign o_bus = {c_ifc_n, c_atn_n, c_ren_n, c_eoi_n & (i_eoi_oe_n | i_eoi_n), c_dav_n & (i_dav_oe_n | i_dav_n),
        c_nrfd_n & (i_nrfd_oe_n | i_nrfd_n), c_ndac_n & (i_ndac_oe_n | i_ndac_n),
        c_dio_n & (i_dio_oe_n ? 8'hFF : i_dio_n)};
    // controller as source of one byte
    task send(input logic atn_n, input logic eoi_n, input logic [7:0] b);
        int n;
        c_nrfd_n = 1'b1;
        c_ndac_n = 1'b1;
        c_atn_n = atn_n;
        @(negedge i_clk);
        for (n = 0; n < 500 && !o_bus.nrfd_n; n++) @(negedge i_clk);
        faults += int'(n == 500);
        c_dio_n = ~b;
        c_eoi_n = eoi_n;
        @(negedge i_clk);
        c_dav_n = 1'b0;
        for (n = 0; n < 500 && !o_bus.ndac_n; n++) @(negedge i_clk);
        faults += int'(n == 500);
        c_dav_n = 1'b1;
        c_dio_n = 8'hFF;
        c_eoi_n = 1'b1;
    endtask : send
    // controller as acceptor; stays not ready afterwards so the talker stalls
    task recv(input int stall, output logic [7:0] b, output logic e);
        int n;
        c_nrfd_n = 1'b0;
        c_ndac_n = 1'b0;
        c_atn_n = 1'b1;
        repeat (stall + 1) @(negedge i_clk);
        c_nrfd_n = 1'b1;
        for (n = 0; n < 500 && o_bus.dav_n; n++) @(negedge i_clk);
        faults += int'(n == 500);
        b = ~o_bus.dio_n;
        e = ~o_bus.eoi_n;
        c_nrfd_n = 1'b0;
        @(negedge i_clk);
        c_ndac_n = 1'b1;
        for (n = 0; n < 500 && !o_bus.dav_n; n++) @(negedge i_clk);
        faults += int'(n == 500);
        c_ndac_n = 1'b0;
    endtask : recv
endmodule : gpib_ctrl_model

// [testbench/gpib_instrument_interface_test.sv]
// self-checking bench for the instrument-side gpib interface
`timescale 1ns/1ps
`include "gpib_cfg.svh"
module gpib_instrument_interface_test;
    import gpib_pkg::*;
    localparam logic [4:0] MY_ADDR = 5'h0B; // primary address under test
    logic clk = 1'b0;
    logic srst = 1'b1;
    gpib_bus_in_type bus;
    logic [7:0] dio_n;
    logic dio_oe_n, dav_n, dav_oe_n, eoi_n, eoi_oe_n, nrfd_n, nrfd_oe_n, ndac_n, ndac_oe_n, srq_n, srq_oe_n;
    gpib_byte_type tx = '0;
    gpib_byte_type rx;
    logic tx_valid = 1'b0;
    logic rx_ready = 1'b0;
    logic rsv = 1'b0;
    logic [6:0] status = 7'h00;
    logic ist = 1'b0;
    logic tx_ready, rx_valid, remote, lockout, listen, talk, dev_clear, trigger;
    logic [7:0] b;
    logic e;
    logic [8:0] words [4] = '{9'h048, 9'h069, 9'h00D, 9'h10A}; // last one ends the message
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int trig_cnt = 0; // pulses are one cycle, so they are counted here
    int clr_cnt = 0;
    gpib_device gpib_device_i (.I_CLK(clk), .I_SRST(srst), .I_MY_ADDR(MY_ADDR), .I_BUS(bus), .O_DIO_N(dio_n),
        .O_DIO_OE_N(dio_oe_n), .O_DAV_N(dav_n), .O_DAV_OE_N(dav_oe_n), .O_EOI_N(eoi_n), .O_EOI_OE_N(eoi_oe_n),
        .O_NRFD_N(nrfd_n), .O_NRFD_OE_N(nrfd_oe_n), .O_NDAC_N(ndac_n), .O_NDAC_OE_N(ndac_oe_n), .O_SRQ_N(srq_n),
        .O_SRQ_OE_N(srq_oe_n), .I_TX(tx), .I_TX_VALID(tx_valid), .O_TX_READY(tx_ready), .O_RX(rx),
        .O_RX_VALID(rx_valid), .I_RX_READY(rx_ready), .I_RSV(rsv), .I_STATUS(status), .I_IST(ist),
        .O_REMOTE(remote), .O_LOCKOUT(lockout), .O_LISTEN(listen), .O_TALK(talk), .O_DEV_CLEAR(dev_clear),
        .O_TRIGGER(trigger));
    gpib_ctrl_model gpib_ctrl_model_i (.i_clk(clk), .i_dio_n(dio_n), .i_dio_oe_n(dio_oe_n), .i_dav_n(dav_n),
        .i_dav_oe_n(dav_oe_n), .i_eoi_n(eoi_n), .i_eoi_oe_n(eoi_oe_n), .i_nrfd_n(nrfd_n),
        .i_nrfd_oe_n(nrfd_oe_n), .i_ndac_n(ndac_n), .i_ndac_oe_n(ndac_oe_n), .o_bus(bus));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    // cycle count, pulse counters and the hang limit
    always @(posedge clk)
    begin
        cycles++;
        trig_cnt += int'(trigger === 1'b1);
        clr_cnt += int'(dev_clear === 1'b1);
        if (cycles == 20000)
        begin
            errors++;
            complete_run();
        end
    end
    task check(input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // interface message under attention
    task cmd(input logic [6:0] c);
        gpib_ctrl_model_i.send(1'b0, 1'b1, {1'b0, c});
        repeat (3) @(negedge clk);
    endtask : cmd
    // wait for a received byte, compare, hand it back
    task take(input logic [8:0] exp);
        for (int n = 0; n < 100 && rx_valid !== 1'b1; n++) @(negedge clk);
        check(rx, exp);
        repeat (3) @(negedge clk);
        check(rx_valid, 1'b1);
        check(bus.nrfd_n, 1'b0);
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
        check(rx_valid, 1'b0);
    endtask : take
    task push(input logic [8:0] v);
        @(negedge clk);
        tx = v;
        tx_valid = 1'b1;
        for (int n = 0; n < 50 && tx_ready !== 1'b1; n++) @(negedge clk);
        @(negedge clk);
        tx_valid = 1'b0;
    endtask : push
    task t_reset;
        check({dio_oe_n, dav_oe_n, eoi_oe_n, nrfd_oe_n, srq_oe_n, listen, talk, remote, rx_valid}, 9'h1F0);
    endtask : t_reset
    task t_listen;
        gpib_ctrl_model_i.c_ren_n = 1'b0;
        cmd({`GPIB_LAD_BASE, MY_ADDR});
        check({listen, talk, remote, rx_valid}, 4'hA);
        gpib_ctrl_model_i.send(1'b1, 1'b1, 8'hA5);
        take(9'h0A5);
        gpib_ctrl_model_i.send(1'b1, 1'b0, 8'h3C);
        take(9'h13C);
    endtask : t_listen
    task t_events;
        cmd(`GPIB_MSG_GET);
        cmd(`GPIB_MSG_SDC);
        cmd(`GPIB_MSG_DCL);
        check(9'(trig_cnt), 9'h001);
        check(9'(clr_cnt), 9'h002);
        cmd(`GPIB_MSG_LLO);
        cmd(`GPIB_MSG_GTL);
        check({remote, lockout}, 2'b01);
    endtask : t_events
    task t_ppoll;
        cmd(`GPIB_MSG_PPC);
        cmd({`GPIB_PPE_BASE, 1'b1, 3'h5});
        ist = 1'b1;
        gpib_ctrl_model_i.c_eoi_n = 1'b0;
        repeat (3) @(negedge clk);
        check(bus.dio_n, 8'hDF);
        ist = 1'b0;
        repeat (3) @(negedge clk);
        check(bus.dio_n, 8'hFF);
        gpib_ctrl_model_i.c_eoi_n = 1'b1;
        cmd(`GPIB_MSG_PPU);
        ist = 1'b1;
        gpib_ctrl_model_i.c_eoi_n = 1'b0;
        repeat (3) @(negedge clk);
        check(bus.dio_n, 8'hFF);
        gpib_ctrl_model_i.c_eoi_n = 1'b1;
    endtask : t_ppoll
    task t_talk;
        for (int i = 0; i < 4; i++) push(words[i]);
        repeat (2) @(negedge clk);
        check(tx_ready, 1'b0);
        cmd({`GPIB_TAD_BASE, MY_ADDR});
        check({listen, talk}, 2'b01);
        for (int i = 0; i < 4; i++)
        begin
            gpib_ctrl_model_i.recv(5, b, e);
            check({e, b}, words[i]);
        end
        repeat (3) @(negedge clk);
        check(tx_ready, 1'b1);
        cmd({`GPIB_LAD_BASE, MY_ADDR});
        check({listen, talk}, 2'b10);
    endtask : t_talk
    task t_spoll;
        rsv = 1'b1;
        status = 7'h15;
        repeat (10) @(negedge clk);
        check(srq_oe_n, 1'b0);
        cmd(`GPIB_MSG_SPE);
        cmd({`GPIB_TAD_BASE, MY_ADDR});
        gpib_ctrl_model_i.recv(0, b, e);
        check({e, b}, 9'h055);
        cmd(`GPIB_MSG_SPD);
        check(srq_oe_n, 1'b1);
        rsv = 1'b0;
        cmd(`GPIB_MSG_UNT);
        check(talk, 1'b0);
    endtask : t_spoll
    task t_ifc;
        cmd({`GPIB_LAD_BASE, MY_ADDR});
        gpib_ctrl_model_i.c_ifc_n = 1'b0;
        repeat (5) @(negedge clk);
        gpib_ctrl_model_i.c_ifc_n = 1'b1;
        @(negedge clk);
        check({listen, talk, remote}, 3'b001);
        gpib_ctrl_model_i.c_ren_n = 1'b1;
        repeat (3) @(negedge clk);
        check(remote, 1'b0);
    endtask : t_ifc
    initial
    begin
        repeat (10) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        t_reset();
        t_listen();
        t_events();
        t_ppoll();
        t_talk();
        t_spoll();
        t_ifc();
        check(9'(gpib_ctrl_model_i.faults), 9'h000);
        complete_run();
    end
endmodule : gpib_instrument_interface_test
